// ==== rtl/itf_consts.svh ====
`ifndef ITF_CONSTS_SVH
`define ITF_CONSTS_SVH

// ==================================================
// data widths
`define ITF_PIX_W       12
`define ITF_FIFO_W      13
`define ITF_FIFO_DEPTH  32
`define ITF_CYC_W       32

// ==================================================
// checksum generator, build-time choice
`define ITF_CRC_W       32
`define ITF_CRC_POLY    32'h04c11db7
`define ITF_CRC_INIT    32'hffffffff

// ==================================================
// trailer layout, build-time choice
// identifiers are arbitrary values, fields d1,d2,d3,d4[0..7]
`define ITF_STAMP_GUID  128'h1a2b3c4d_5e6f_7081_92a3b4c5d6e7f809
`define ITF_CRC_GUID    128'h0f1e2d3c_4b5a_6978_8796a5b4c3d2e1f0
`define ITF_CRC_FIRST   1'b0
`define ITF_GUID_BYTES  5'h10
`define ITF_TRL_LAST    5'h13

// ==================================================
// test image ramp
`define ITF_PAT_STEP    12'h001

`endif

// ==== rtl/itf_pkg.sv ====
package itf_pkg;

  // gray order: idle, low byte, high byte, trailer
  typedef enum logic [1:0] {
    ITF_IDLE   = 2'h0,
    ITF_PIX_LO = 2'h1,
    ITF_PIX_HI = 2'h3,
    ITF_TRL    = 2'h2
  } itf_state_e;

  typedef struct packed {
    logic [31:0] d1;
    logic [15:0] d2;
    logic [15:0] d3;
    logic [63:0] d4;
  } itf_guid_s;

  // byte i of the result is the i-th byte on the wire
  function automatic logic [127:0] itf_guid_bytes(input itf_guid_s g);
    logic [127:0] v;
    v = '0;
    v[31:0]  = g.d1;
    v[47:32] = g.d2;
    v[63:48] = g.d3;
    for (int k = 0; k < 8; k++) begin
      v[64 + 8*k +: 8] = g.d4[63 - 8*k -: 8];
    end
    return v;
  endfunction

endpackage

// ==== rtl/itf_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module itf_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  // drain side
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  // ==================================================
  // storage, no reset needed on the array
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ==================================================
  // pointers; ready is registered so the pin sees a flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop)  rd_ptr <= rd_ptr + AW'(1);
      count    <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
    end
  end

endmodule

`default_nettype wire

// ==== rtl/itf_crc.sv ====
`timescale 1ns/1ps
`default_nettype none

module itf_crc #(
  parameter logic [31:0] POLY = 32'h04c11db7,
  parameter logic [31:0] INIT = 32'hffffffff
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // byte feed
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // running value
  output var  logic [31:0] crc
);

  logic [31:0] next_crc;

  // msb-first, one byte per cycle
  always_comb begin
    next_crc = crc;
    for (int i = 7; i >= 0; i--) begin
      if (next_crc[31] ^ data[i]) begin
        next_crc = {next_crc[30:0], 1'b0} ^ POLY;
      end else begin
        next_crc = {next_crc[30:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clr) begin
      crc <= INIT;
    end else if (en) begin
      crc <= next_crc;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/itf_framer.sv ====
// What this block does
// - 16-bit mode: low byte, then high byte
// - upper four bits zero, maximum 0x0fff
// - test enabled: generated image replaces sensor data
// - time stamp: latch cycle time at exposure
// - checksum enabled: crc over each image
// - feature results follow the frame's pixel data
// - each result carries its feature identifier
// - one control register per feature
// - identifiers are 128 bits: 32,16,16,8x8
// - extended stream off suppresses every trailer
`timescale 1ns/1ps
`default_nettype none
`include "itf_consts.svh"

module itf_framer
  import itf_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // feature controls
  input  wire logic                   ctl_wide16,
  input  wire logic                   ctl_test,
  input  wire logic                   ctl_stamp,
  input  wire logic                   ctl_crc,
  input  wire logic                   ctl_ext,
  // exposure timing
  input  wire logic                   exp_start_pin,
  input  wire logic [`ITF_CYC_W-1:0]  cycle_time,
  // sensor pixels
  input  wire logic                   pix_valid,
  input  wire logic [`ITF_PIX_W-1:0]  pix_data,
  input  wire logic                   pix_eof,
  output var  logic                   pix_ready,
  // byte stream out
  output var  logic                   out_valid,
  output var  logic [7:0]             out_data,
  output var  logic                   out_last,
  input  wire logic                   out_ready
);

  // ==================================================
  // identifiers
  // 128-bit identifier layout
  localparam logic [127:0] STAMP_GVEC = itf_guid_bytes(itf_guid_s'(`ITF_STAMP_GUID));
  localparam logic [127:0] CRC_GVEC   = itf_guid_bytes(itf_guid_s'(`ITF_CRC_GUID));

  itf_state_e                st;
  itf_state_e                next_st;
  logic                      f_wide;
  logic                      f_test;
  logic                      f_stamp;
  logic                      f_crc;
  logic                      f_ext;
  logic [`ITF_PIX_W-1:0]     pat_val;
  logic                      exp_sync1;
  logic                      exp_sync2;
  logic                      exp_prev;
  logic [`ITF_CYC_W-1:0]     stamp_hold;
  logic [`ITF_CYC_W-1:0]     frame_stamp;
  logic                      trl_feat;
  logic                      trl_second;
  logic [4:0]                trl_idx;
  logic                      fq_valid;
  logic                      fq_pop;
  logic [`ITF_FIFO_W-1:0]    fq_data;
  logic [`ITF_CRC_W-1:0]     crc_val;

  // ==================================================
  // pixel buffer
  // pixels queue here so a stalled output back-pressures the sensor side
  itf_fifo #(
    .WIDTH (`ITF_FIFO_W),
    .DEPTH (`ITF_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (pix_valid),
    .in_data   ({pix_eof, pix_data}),
    .in_ready  (pix_ready),
    .out_valid (fq_valid),
    .out_data  (fq_data),
    .out_ready (fq_pop)
  );

  // ==================================================
  // decode
  wire adv       = !out_valid || out_ready;
  wire in_pix    = (st == ITF_PIX_LO) || (st == ITF_PIX_HI);
  wire byte_go   = adv && ((in_pix && fq_valid) || (st == ITF_TRL));
  wire pix_go    = byte_go && in_pix;
  assign fq_pop  = pix_go && ((st == ITF_PIX_HI) || !f_wide);
  wire head_eof  = fq_data[`ITF_FIFO_W-1];
  wire frame_end = fq_pop && head_eof;
  wire start     = (st == ITF_IDLE) && fq_valid;
  wire exp_edge  = exp_sync2 && !exp_prev;

  wire [`ITF_PIX_W-1:0] pix_val = f_test ? pat_val : fq_data[`ITF_PIX_W-1:0];

  // low byte first, high byte second
  // high byte carries only four live bits
  wire [7:0] hi_byte  = {4'h0, pix_val[11:8]};
  wire [7:0] lo_byte  = f_wide ? pix_val[7:0] : pix_val[11:4];
  wire [7:0] pix_byte = (st == ITF_PIX_HI) ? hi_byte : lo_byte;

  wire want_stamp = f_ext && f_stamp;
  wire want_crc   = f_ext && f_crc;
  wire any_trl    = want_stamp || want_crc;
  wire first_crc  = `ITF_CRC_FIRST ? want_crc : !want_stamp;
  wire last_item  = trl_second || !(want_stamp && want_crc);
  wire trl_end    = (st == ITF_TRL) && (trl_idx == `ITF_TRL_LAST);

  wire [127:0] gvec     = trl_feat ? CRC_GVEC : STAMP_GVEC;
  wire [31:0]  fvalue   = trl_feat ? crc_val : frame_stamp;
  wire         in_guid  = trl_idx < `ITF_GUID_BYTES;
  wire [7:0]   g_byte   = gvec[{trl_idx[3:0], 3'h0} +: 8];
  wire [7:0]   v_byte   = fvalue[{trl_idx[1:0], 3'h0} +: 8];
  wire [7:0]   trl_byte = in_guid ? g_byte : v_byte;

  wire [7:0] next_byte = (st == ITF_TRL) ? trl_byte : pix_byte;
  wire       next_last = (frame_end && !any_trl) || (trl_end && last_item);

  // ==================================================
  // checksum over the bytes as sent
  // crc of each transmitted image
  itf_crc #(
    .POLY (`ITF_CRC_POLY),
    .INIT (`ITF_CRC_INIT)
  ) u_crc (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clr     (start),
    .en      (pix_go && f_crc),
    .data    (pix_byte),
    .crc     (crc_val)
  );

  // ==================================================
  // sequencer
  always_comb begin
    next_st = st;
    case (st)
      ITF_IDLE: begin
        if (fq_valid) next_st = ITF_PIX_LO;
      end
      ITF_PIX_LO: begin
        if (pix_go && f_wide) begin
          next_st = ITF_PIX_HI;
        end else if (frame_end) begin
          next_st = any_trl ? ITF_TRL : ITF_IDLE;
        end
      end
      ITF_PIX_HI: begin
        if (frame_end) begin
          next_st = any_trl ? ITF_TRL : ITF_IDLE;
        end else if (pix_go) begin
          next_st = ITF_PIX_LO;
        end
      end
      ITF_TRL: begin
        if (byte_go && trl_end && last_item) next_st = ITF_IDLE;
      end
      default: next_st = ITF_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) st <= ITF_IDLE;
    else         st <= next_st;
  end

  // ==================================================
  // per-feature control, held steady for the whole frame
  // one register per feature
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      f_wide  <= 1'b0;
      f_test  <= 1'b0;
      f_stamp <= 1'b0;
      f_crc   <= 1'b0;
      f_ext   <= 1'b0;
    end else if (start) begin
      f_wide  <= ctl_wide16;
      f_test  <= ctl_test;
      f_stamp <= ctl_stamp;
      f_crc   <= ctl_crc;
      f_ext   <= ctl_ext;
    end
  end

  // ==================================================
  // test ramp, restarts each frame
  // generated pixel values
  always_ff @(posedge clk_sys) begin
    if (sys_rst || start) begin
      pat_val <= '0;
    end else if (fq_pop) begin
      pat_val <= pat_val + `ITF_PAT_STEP;
    end
  end

  // ==================================================
  // exposure start, pin sync then rising edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      exp_sync1 <= 1'b0;
      exp_sync2 <= 1'b0;
      exp_prev  <= 1'b0;
    end else begin
      exp_sync1 <= exp_start_pin;
      exp_sync2 <= exp_sync1;
      exp_prev  <= exp_sync2;
    end
  end

  // latch cycle time at exposure
  // a second exposure before frame start overwrites the first
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stamp_hold  <= '0;
      frame_stamp <= '0;
    end else begin
      if (exp_edge && ctl_stamp) stamp_hold <= cycle_time;
      if (start) frame_stamp <= stamp_hold;
    end
  end

  // ==================================================
  // trailer walk
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      trl_idx    <= '0;
      trl_feat   <= 1'b0;
      trl_second <= 1'b0;
    end else if (frame_end) begin
      trl_idx    <= '0;
      trl_feat   <= first_crc;
      trl_second <= 1'b0;
    end else if (byte_go && (st == ITF_TRL)) begin
      trl_idx <= trl_end ? 5'h0 : trl_idx + 5'h1;
      if (trl_end) begin
        trl_feat   <= !trl_feat;
        trl_second <= 1'b1;
      end
    end
  end

  // ==================================================
  // output register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
    end else if (adv) begin
      out_valid <= byte_go;
      out_data  <= next_byte;
      out_last  <= byte_go && next_last;
    end
  end

  // ==================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_low_then_high: assert property (
    (st == ITF_PIX_LO && pix_go && f_wide) |=> (st == ITF_PIX_HI) && $stable(fq_data)
  ) else $error("high byte does not follow low byte");

  a_high_nibble_zero: assert property (
    (st == ITF_PIX_HI && pix_go) |=> out_valid && (out_data[7:4] == 4'h0)
  ) else $error("16-bit value exceeds 0x0fff");

  a_test_image_data: assert property (
    (st == ITF_PIX_LO && pix_go && f_wide && f_test) |=> out_data == 8'($past(pat_val))
  ) else $error("test image byte not sent");

  a_stamp_latch: assert property (
    (exp_edge && ctl_stamp) |=> stamp_hold == $past(cycle_time)
  ) else $error("cycle time not latched at exposure");

  a_crc_held_trailer: assert property (
    (st == ITF_TRL) |=> $stable(crc_val)
  ) else $error("checksum changed during trailer");

  a_trailer_after_pix: assert property (
    (frame_end && any_trl) |=> (st == ITF_TRL) && (trl_idx == 5'h0)
  ) else $error("trailer does not follow last pixel");

  a_guid_first_byte: assert property (
    (st == ITF_TRL && byte_go && trl_idx == 5'h0 && trl_feat) |=> out_data == CRC_GVEC[7:0]
  ) else $error("result not led by its identifier");

  a_ctl_frame_held: assert property (
    (st != ITF_IDLE) |=> $stable(f_crc) && $stable(f_stamp) && $stable(f_test)
  ) else $error("feature control changed mid-frame");

  a_ext_gates_trl: assert property (
    !f_ext |-> st != ITF_TRL
  ) else $error("trailer sent with extended stream off");

  c_wide_frame: cover property (start ##1 f_wide ##[1:40] frame_end);
  c_two_results: cover property (trl_end && byte_go && !last_item ##1 trl_second);
  c_out_stall:  cover property (out_valid && !out_ready [*3]);
  c_fifo_full:  cover property (pix_valid && !pix_ready);

endmodule

`default_nettype wire

// ==== test/itf_host_sink.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==================================================
// host side: takes bytes, may stall or pace
module itf_host_sink (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // byte stream
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output var  logic       out_ready,
  // pacing
  input  wire logic       hold,
  input  wire logic       slow
);
  logic [8:0] got[$];
  logic       ph;

  // ready only changes after an edge, slow mode halves the rate
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      out_ready <= 1'b0;
      ph        <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        got.push_back({out_last, out_data});
      end
      ph        <= ~ph;
      out_ready <= !hold && (!slow || ph);
    end
  end
endmodule

`default_nettype wire

// ==== test/itf_framer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "itf_consts.svh"

module itf_framer_tb
  import itf_pkg::*;
;
  // ==================================================
  // stimulus and wiring
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ctl_wide16 = 1'b0, ctl_test = 1'b0, ctl_stamp = 1'b0;
  logic        ctl_crc = 1'b0, ctl_ext = 1'b0, exp_start_pin = 1'b0;
  logic [31:0] cycle_time = 32'h0;
  logic        pix_valid = 1'b0, pix_eof = 1'b0, hold = 1'b0, slow = 1'b0;
  logic [11:0] pix_data = 12'h0;
  wire logic   pix_ready, out_valid, out_last, out_ready;
  wire logic [7:0] out_data;
  int          fails = 0;
  int          n_compared = 0;
  logic [7:0]  exq[$];
  logic [11:0] pq[$];
  logic [31:0] crc_x;

  always #4 clk_sys = ~clk_sys;

  itf_framer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ctl_wide16(ctl_wide16),
    .ctl_test(ctl_test), .ctl_stamp(ctl_stamp), .ctl_crc(ctl_crc), .ctl_ext(ctl_ext),
    .exp_start_pin(exp_start_pin), .cycle_time(cycle_time), .pix_valid(pix_valid),
    .pix_data(pix_data), .pix_eof(pix_eof), .pix_ready(pix_ready), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

  itf_host_sink i_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready), .hold(hold),
    .slow(slow));

  // ==================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic timeout;
    fails++;
    tally_and_finish;
  endtask

  // msb first, no final inversion
  task automatic crc_byte(input logic [7:0] b);
    logic fb;
    for (int k = 0; k < 8; k++) begin
      fb    = crc_x[31] ^ b[7-k];
      crc_x = {crc_x[30:0], 1'b0} ^ (fb ? `ITF_CRC_POLY : 32'h0);
    end
  endtask

  task automatic add_pix(input logic [11:0] v);
    if (ctl_wide16) begin
      exq.push_back(v[7:0]);
      exq.push_back({4'h0, v[11:8]});
      crc_byte(v[7:0]);
      crc_byte({4'h0, v[11:8]});
    end else begin
      exq.push_back(v[11:4]);
      crc_byte(v[11:4]);
    end
  endtask

  task automatic add_item(input logic [127:0] gv, input logic [31:0] val);
    itf_guid_s g;
    g = gv;
    for (int k = 0; k < 4; k++) exq.push_back(g.d1[8*k +: 8]);
    for (int k = 0; k < 2; k++) exq.push_back(g.d2[8*k +: 8]);
    for (int k = 0; k < 2; k++) exq.push_back(g.d3[8*k +: 8]);
    for (int k = 0; k < 8; k++) exq.push_back(g.d4[63-8*k -: 8]);
    for (int k = 0; k < 4; k++) exq.push_back(val[8*k +: 8]);
  endtask

  task automatic prep(input logic w, input logic t, input logic s, input logic c,
                      input logic e);
    @(negedge clk_sys);
    {ctl_wide16, ctl_test, ctl_stamp, ctl_crc, ctl_ext} = {w, t, s, c, e};
    exq.delete();
    pq.delete();
    crc_x = `ITF_CRC_INIT;
  endtask

  task automatic send(input int from);
    int n;
    for (int i = from; i < pq.size(); i++) begin
      @(negedge clk_sys);
      pix_valid = 1'b1;
      pix_data  = pq[i];
      pix_eof   = (i == pq.size() - 1);
      n = 0;
      while (pix_ready !== 1'b1) begin
        @(negedge clk_sys);
        n++;
        if (n > 2000) timeout;
      end
    end
    @(negedge clk_sys);
    pix_valid = 1'b0;
    pix_eof   = 1'b0;
  endtask

  task automatic run_frame(input int from);
    int base;
    int n;
    base = i_host.got.size();
    send(from);
    n = 0;
    while (i_host.got.size() < base + exq.size()) begin
      @(negedge clk_sys);
      n++;
      if (n > 5000) timeout;
    end
    repeat (20) @(negedge clk_sys);
    check(i_host.got.size(), base + exq.size());
    foreach (exq[i]) begin
      check(i_host.got[base+i][7:0], exq[i]);
      check(i_host.got[base+i][8], i == exq.size() - 1);
    end
  endtask

  // ==================================================
  // scenarios
  task automatic s_wide;
    prep(1, 0, 0, 0, 0);
    pq = '{12'habc, 12'hfff, 12'h000, 12'h801};
    foreach (pq[i]) add_pix(pq[i]);
    run_frame(0);
  endtask

  task automatic s_narrow;
    prep(0, 0, 0, 0, 0);
    pq = '{12'habc, 12'h0f0};
    foreach (pq[i]) add_pix(pq[i]);
    run_frame(0);
  endtask

  task automatic s_test;
    prep(1, 1, 0, 0, 0);
    pq = '{12'h555, 12'h555, 12'h555};
    for (int i = 0; i < 3; i++) add_pix(12'(i) * `ITF_PAT_STEP);
    run_frame(0);
  endtask

  // stamp must be the value at exposure, not at frame start
  task automatic s_trailer;
    prep(1, 0, 1, 1, 1);
    slow = 1'b1;
    cycle_time = 32'h1234_5678;
    exp_start_pin = 1'b1;
    @(negedge clk_sys);
    exp_start_pin = 1'b0;
    repeat (8) @(negedge clk_sys);
    cycle_time = 32'hdead_0001;
    pq = '{12'h123, 12'hfed, 12'h07f};
    foreach (pq[i]) add_pix(pq[i]);
    add_item(`ITF_STAMP_GUID, 32'h1234_5678);
    add_item(`ITF_CRC_GUID, crc_x);
    run_frame(0);
    slow = 1'b0;
  endtask

  task automatic s_ext_off;
    prep(1, 0, 1, 1, 0);
    pq = '{12'h321, 12'h654};
    foreach (pq[i]) add_pix(pq[i]);
    run_frame(0);
  endtask

  // host stalls until the fifo refuses, then drains slowly
  task automatic s_fill;
    int n;
    prep(1, 0, 0, 1, 1);
    for (int i = 0; i < 40; i++) pq.push_back(12'(i * 103));
    foreach (pq[i]) add_pix(pq[i]);
    add_item(`ITF_CRC_GUID, crc_x);
    hold = 1'b1;
    n = 0;
    while (n < 40) begin
      @(negedge clk_sys);
      pix_valid = 1'b1;
      pix_data  = pq[n];
      pix_eof   = (n == 39);
      if (pix_ready !== 1'b1) break;
      n++;
    end
    check(pix_ready, 1'b0);
    check(n, `ITF_FIFO_DEPTH);
    hold = 1'b0;
    slow = 1'b1;
    run_frame(n);
    slow = 1'b0;
  endtask

  // ==================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    check(out_valid, 1'b0);
    s_wide;
    s_narrow;
    s_test;
    s_trailer;
    s_ext_off;
    s_fill;
    tally_and_finish;
  end
endmodule

`default_nettype wire
